// [hdl/doorbell_pkg.sv]
// Constants and types shared by the host doorbell and watchdog logic
package doorbell_pkg;

  // Shared-memory offsets of the doorbell registers
  localparam logic [15:0] OFS_TRIGGER  = 16'h0002;  // Host cause trigger, write one to set
  localparam logic [15:0] OFS_CONFIRM  = 16'h0003;  // Host cause confirm, read only
  localparam logic [15:0] OFS_MASK     = 16'h0004;  // Board cause interrupt mask
  localparam logic [15:0] OFS_CAUSE    = 16'h0005;  // Board cause indication, read only
  localparam logic [15:0] OFS_CLEAR    = 16'h0006;  // Board cause clear, write one to clear
  localparam logic [15:0] OFS_STATUS   = 16'h0007;  // Halt status, read only
  localparam logic [15:0] OFS_WDT_CTRL = 16'h0008;  // Watchdog enable and window
  localparam logic [15:0] OFS_CMD      = 16'h0009;  // Command code

  // Host-to-board cause bit positions
  localparam int HC_EVT_TX   = 0;  // Event transmission notice
  localparam int HC_EVT_ACK  = 1;  // Acknowledge of a board event
  localparam int HC_CMD      = 2;  // Command notice
  localparam int HC_IO_REQ   = 3;  // Request I/O area access right
  localparam int HC_IO_REL   = 4;  // Release I/O area access right
  localparam int HC_WDT_REF  = 5;  // Watchdog refresh

  // Board-to-host cause bit positions
  localparam int BC_EVT_TX   = 0;  // Event transmission notice
  localparam int BC_EVT_ACK  = 1;  // Acknowledge of a host event
  localparam int BC_CMD_ACK  = 2;  // Command acknowledge
  localparam int BC_RST_REQ  = 3;  // Board reset request
  localparam int BC_INIT     = 4;  // Initialization complete
  localparam int BC_IO_GRANT = 5;  // I/O access right granted
  localparam int BC_WDT_TO   = 6;  // Watchdog timeout

  // Field positions
  localparam int WDT_EN_BIT    = 0;  // Watchdog enable in control register
  localparam int WDT_WIN_LSB   = 1;  // Window field low bit
  localparam int WDT_WIN_W     = 7;  // Window field width in bits; the window counts ticks
  localparam int STAT_FAULT    = 0;  // Hardware fault halt
  localparam int STAT_WDT      = 1;  // Watchdog halt

  // Reset values
  localparam logic [7:0] REG_RST = 8'h00;

  // Command codes
  localparam logic [7:0] CODE_START       = 8'h01;
  localparam logic [7:0] CODE_START_EX    = 8'h02;
  localparam logic [7:0] CODE_IO_START    = 8'h03;
  localparam logic [7:0] CODE_IO_STOP     = 8'h04;
  localparam logic [7:0] CODE_STOP        = 8'h05;
  localparam logic [7:0] CODE_STAT_READ   = 8'h06;
  localparam logic [7:0] CODE_STAT_CLEAR  = 8'h07;

  // Timing
  localparam int CLK_PERIOD_NS = 50;       // System clock period
  localparam int WDT_TICK_NS   = 1000000;  // Watchdog tick, 1 ms

  // Decoded command
  typedef enum logic [2:0] {
    OP_NONE, OP_START, OP_START_EX, OP_IO_START, OP_IO_STOP, OP_STOP, OP_STAT_READ, OP_STAT_CLEAR
  } cmd_op_type;

  // Communication cycle state
  typedef enum logic [1:0] {CYC_OFF, CYC_IDLE, CYC_RUN, CYC_HALT} cyc_state_type;

endpackage

// [hdl/host_watchdog_timer.sv]
// Host watchdog: counts ticks since the last refresh and flags expiry
`timescale 1ns/10ps
module host_watchdog_timer #(
  parameter int TICK_CYCLES = 20000,
  parameter int WIN_W       = 7
) (
  // Clock and control
  input  wire logic             i_sys_clk,
  input  wire logic             i_rst_n,
  input  wire logic             i_ce,
  // Configuration and refresh
  input  wire logic             i_enable,
  input  wire logic [WIN_W-1:0] i_window,
  input  wire logic             i_refresh,
  // Expiry level, held until disabled
  output logic                  o_expire
);

  localparam int TW = $clog2(TICK_CYCLES + 1);

  // All timer state
  typedef struct packed {
    logic [TW-1:0]    tick;    // Prescaler
    logic [WIN_W-1:0] ticks;   // Ticks since refresh
    logic             expire;  // Window missed
  } wdt_state_type;

  wdt_state_type st_q;  // Registered state
  wdt_state_type st_d;  // Next state

  // Prescale, count ticks and compare with the window
  always_comb begin
    st_d = st_q;
    if (i_ce) begin
      if (!i_enable || i_refresh) begin
        // Disabled or refreshed: restart the window
        st_d.tick   = '0;
        st_d.ticks  = '0;
        st_d.expire = !i_enable ? 1'b0 : st_q.expire;
      end else if (!st_q.expire) begin
        if (st_q.tick == TW'(TICK_CYCLES - 1)) begin
          st_d.tick  = '0;
          st_d.ticks = st_q.ticks + 1'b1;
          // Expire once the window in ticks has elapsed
          if (st_q.ticks + 1'b1 >= i_window) begin
            st_d.expire = 1'b1;
          end
        end else begin
          st_d.tick = st_q.tick + 1'b1;
        end
      end
    end
  end

  // State register
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign o_expire = st_q.expire;

endmodule // host_watchdog_timer

// [hdl/host_board_doorbell_watchdog.sv]
// Host doorbell, board causes, command decode and host watchdog of the board
`timescale 1ns/10ps
module host_board_doorbell_watchdog #(
  parameter int TICK_CYCLES = doorbell_pkg::WDT_TICK_NS / doorbell_pkg::CLK_PERIOD_NS
) (
  // Clock, reset, enable
  input  wire logic        i_sys_clk,
  input  wire logic        i_rst_n,
  input  wire logic        i_ce,
  // Shared-memory port from the host
  input  wire logic [15:0] i_host_addr,
  input  wire logic        i_host_wr,
  input  wire logic        i_host_rd,
  input  wire logic [7:0]  i_host_wdata,
  output logic      [7:0]  o_host_rdata,
  // Board firmware side
  output logic      [7:0]  o_host_cause_pending,
  input  wire logic [7:0]  i_host_done,
  input  wire logic [7:0]  i_board_cause_set,
  input  wire logic        i_hw_fault,
  // Bus interrupt and communication control
  output logic             o_bus_irq_n,
  output logic             o_comm_halt,
  output logic             o_cycle_run,
  output logic             o_io_run,
  output logic             o_status_read_req,
  output logic             o_status_clear_req
);

  // Address match, used for the register writes
  function automatic logic hit(input logic [15:0] addr, input logic [15:0] ofs);
    return addr == ofs;
  endfunction

  // Command code to operation
  function automatic doorbell_pkg::cmd_op_type decode_cmd(input logic [7:0] code);
    case (code)
      doorbell_pkg::CODE_START:      decode_cmd = doorbell_pkg::OP_START;
      doorbell_pkg::CODE_START_EX:   decode_cmd = doorbell_pkg::OP_START_EX;
      doorbell_pkg::CODE_IO_START:   decode_cmd = doorbell_pkg::OP_IO_START;
      doorbell_pkg::CODE_IO_STOP:    decode_cmd = doorbell_pkg::OP_IO_STOP;
      doorbell_pkg::CODE_STOP:       decode_cmd = doorbell_pkg::OP_STOP;
      doorbell_pkg::CODE_STAT_READ:  decode_cmd = doorbell_pkg::OP_STAT_READ;
      doorbell_pkg::CODE_STAT_CLEAR: decode_cmd = doorbell_pkg::OP_STAT_CLEAR;
      default:                       decode_cmd = doorbell_pkg::OP_NONE;
    endcase
  endfunction

  // All block state
  typedef struct packed {
    logic [7:0]                  confirm;   // Host causes in progress
    logic [7:0]                  cause;     // Board causes pending
    logic [7:0]                  mask;      // Interrupt enable per cause
    logic [7:0]                  wdt_ctrl;  // Watchdog enable and window
    logic [7:0]                  cmd_code;  // Command code
    logic [7:0]                  rdata;     // Read data
    logic                        irq_n;     // Bus interrupt, low active
    logic                        fault;     // Hardware fault halt
    logic                        wdt_halt;  // Watchdog halt
    logic                        refresh;   // Refresh pulse to timer
    logic                        run;       // Cycle running
    logic                        io_run;    // I/O exchange running
    logic                        stat_rd;   // Status read pulse
    logic                        stat_clr;  // Status clear pulse
    logic                        halt;      // Communications halted
    doorbell_pkg::cyc_state_type cyc;       // Cycle state
  } blk_state_type;

  blk_state_type st_q;     // Registered state
  blk_state_type st_d;     // Next state
  logic          wdt_exp;  // Watchdog expired

  // Watchdog counter
  host_watchdog_timer #(
    .TICK_CYCLES (TICK_CYCLES),
    .WIN_W       (doorbell_pkg::WDT_WIN_W)
  ) u_wdt (
    .i_sys_clk (i_sys_clk),
    .i_rst_n   (i_rst_n),
    .i_ce      (i_ce),
    .i_enable  (st_q.wdt_ctrl[doorbell_pkg::WDT_EN_BIT]),
    .i_window  (st_q.wdt_ctrl[doorbell_pkg::WDT_WIN_LSB +: doorbell_pkg::WDT_WIN_W]),
    .i_refresh (st_q.refresh),
    .o_expire  (wdt_exp)
  );

  // Next-state logic for doorbells, causes, commands and halts
  always_comb begin
    logic [7:0] set_c;  // Board causes raised this cycle
    logic [7:0] clr_c;  // Board causes cleared by host
    logic       wr;     // Host write this cycle
    set_c = i_board_cause_set;
    clr_c = '0;
    wr    = i_ce && i_host_wr;
    st_d  = st_q;
    if (i_ce) begin
      // Pulses last one enabled cycle, so a low enable freezes them too
      st_d.refresh  = 1'b0;
      st_d.stat_rd  = 1'b0;
      st_d.stat_clr = 1'b0;
      // Firmware completes host causes independently
      st_d.confirm = st_q.confirm & ~i_host_done;
      // Command notice: decode, complete and acknowledge
      if (st_q.confirm[doorbell_pkg::HC_CMD]) begin
        st_d.confirm[doorbell_pkg::HC_CMD] = 1'b0;
        set_c[doorbell_pkg::BC_CMD_ACK] = 1'b1;
        case (decode_cmd(st_q.cmd_code))
          doorbell_pkg::OP_START: begin
            // Start refused while halted
            if (st_q.cyc != doorbell_pkg::CYC_HALT) st_d.cyc = doorbell_pkg::CYC_RUN;
          end
          doorbell_pkg::OP_START_EX: begin
            // Detailed start leaves I/O for manual startup
            if (st_q.cyc != doorbell_pkg::CYC_HALT) st_d.cyc = doorbell_pkg::CYC_IDLE;
          end
          doorbell_pkg::OP_IO_START: begin
            if (st_q.cyc == doorbell_pkg::CYC_IDLE) st_d.cyc = doorbell_pkg::CYC_RUN;
          end
          doorbell_pkg::OP_IO_STOP: begin
            if (st_q.cyc == doorbell_pkg::CYC_RUN) st_d.cyc = doorbell_pkg::CYC_IDLE;
          end
          doorbell_pkg::OP_STOP: begin
            if (st_q.cyc != doorbell_pkg::CYC_HALT) st_d.cyc = doorbell_pkg::CYC_OFF;
          end
          doorbell_pkg::OP_STAT_READ:  st_d.stat_rd  = 1'b1;
          doorbell_pkg::OP_STAT_CLEAR: st_d.stat_clr = 1'b1;
          default: ;  // Unknown code is acknowledged only
        endcase
      end
      // Watchdog refresh completes on the spot
      if (st_q.confirm[doorbell_pkg::HC_WDT_REF]) begin
        st_d.confirm[doorbell_pkg::HC_WDT_REF] = 1'b0;
        st_d.refresh = 1'b1;
      end
      // Register writes; a trigger wins over a completion
      if (wr && hit(i_host_addr, doorbell_pkg::OFS_TRIGGER)) begin
        st_d.confirm = st_d.confirm | i_host_wdata;
      end
      if (wr && hit(i_host_addr, doorbell_pkg::OFS_MASK)) st_d.mask = i_host_wdata;
      if (wr && hit(i_host_addr, doorbell_pkg::OFS_WDT_CTRL)) st_d.wdt_ctrl = i_host_wdata;
      if (wr && hit(i_host_addr, doorbell_pkg::OFS_CMD)) st_d.cmd_code = i_host_wdata;
      if (wr && hit(i_host_addr, doorbell_pkg::OFS_CLEAR)) clr_c = i_host_wdata;
      // Halts latch until reset
      if (i_hw_fault) st_d.fault = 1'b1;
      if (wdt_exp && !st_q.wdt_halt) begin
        st_d.wdt_halt = 1'b1;
        set_c[doorbell_pkg::BC_WDT_TO] = 1'b1;
      end
      if (st_d.fault || st_d.wdt_halt) st_d.cyc = doorbell_pkg::CYC_HALT;
      // Board causes: a new event wins over a clear
      st_d.cause  = (st_q.cause & ~clr_c) | set_c;
      st_d.irq_n  = ~|(st_d.cause & st_d.mask);
      st_d.run    = (st_d.cyc == doorbell_pkg::CYC_IDLE) || (st_d.cyc == doorbell_pkg::CYC_RUN);
      st_d.io_run = st_d.cyc == doorbell_pkg::CYC_RUN;
      st_d.halt   = st_d.cyc == doorbell_pkg::CYC_HALT;
      // Read data; unmapped offsets read zero
      if (i_host_rd) begin
        case (i_host_addr)
          doorbell_pkg::OFS_TRIGGER,
          doorbell_pkg::OFS_CONFIRM:  st_d.rdata = st_q.confirm;
          doorbell_pkg::OFS_MASK:     st_d.rdata = st_q.mask;
          doorbell_pkg::OFS_CAUSE:    st_d.rdata = st_q.cause;
          doorbell_pkg::OFS_STATUS:   st_d.rdata = {6'h00, st_q.wdt_halt, st_q.fault};
          doorbell_pkg::OFS_WDT_CTRL: st_d.rdata = st_q.wdt_ctrl;
          doorbell_pkg::OFS_CMD:      st_d.rdata = st_q.cmd_code;
          default:                    st_d.rdata = doorbell_pkg::REG_RST;
        endcase
      end
    end
  end

  // State register
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      st_q       <= '0;
      st_q.irq_n <= 1'b1;
      st_q.cyc   <= doorbell_pkg::CYC_OFF;
    end else begin
      st_q <= st_d;
    end
  end

  // Outputs straight from flops
  assign o_host_rdata         = st_q.rdata;
  assign o_host_cause_pending = st_q.confirm;
  assign o_bus_irq_n          = st_q.irq_n;
  assign o_comm_halt          = st_q.halt;
  assign o_cycle_run          = st_q.run;
  assign o_io_run             = st_q.io_run;
  assign o_status_read_req    = st_q.stat_rd;
  assign o_status_clear_req   = st_q.stat_clr;

  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_rst_n);

  // Trigger write and its confirm flags
  sequence s_trig_wr;
    i_ce && i_host_wr && i_host_addr == doorbell_pkg::OFS_TRIGGER;
  endsequence
  sequence s_cmd_posted;
    i_ce && st_q.confirm[doorbell_pkg::HC_CMD] && !i_host_wr;
  endsequence
  sequence s_cmd_acked;
    !st_q.confirm[doorbell_pkg::HC_CMD] && st_q.cause[doorbell_pkg::BC_CMD_ACK];
  endsequence

  AST_TRIG_SETS_CONFIRM: assert property (s_trig_wr
    |=> (st_q.confirm & $past(i_host_wdata)) == $past(i_host_wdata))
    else $error("Trigger write did not set confirm flags");
  AST_DONE_CLEARS: assert property (i_ce && !i_host_wr && i_host_done != 8'h00
    |=> (st_q.confirm & $past(i_host_done)) == 8'h00)
    else $error("Completed cause still pending");
  AST_CMD_ACK: assert property (s_cmd_posted |=> s_cmd_acked)
    else $error("Command not completed and acknowledged");
  AST_REFRESH: assert property (i_ce && st_q.confirm[doorbell_pkg::HC_WDT_REF] && !i_host_wr
    |=> st_q.refresh && !st_q.confirm[doorbell_pkg::HC_WDT_REF])
    else $error("Watchdog refresh not handled");
  AST_IRQ_GATE: assert property (o_bus_irq_n == !(|(st_q.cause & st_q.mask)))
    else $error("Interrupt does not follow masked causes");
  AST_CLEAR: assert property (i_ce && i_host_wr && i_host_addr == doorbell_pkg::OFS_CLEAR && i_board_cause_set == 8'h00
    && !wdt_exp && !st_q.confirm[doorbell_pkg::HC_CMD] |=> (st_q.cause & $past(i_host_wdata)) == 8'h00)
    else $error("Cleared cause still pending");
  AST_SET_WINS: assert property (i_ce && i_board_cause_set != 8'h00
    |=> (st_q.cause & $past(i_board_cause_set)) == $past(i_board_cause_set))
    else $error("Board cause lost");
  AST_WDT_HALT: assert property (i_ce && wdt_exp && !st_q.wdt_halt |=> o_comm_halt && !o_cycle_run
    && st_q.cause[doorbell_pkg::BC_WDT_TO] ##1 o_comm_halt)
    else $error("Watchdog expiry did not halt");
  AST_FAULT_REPORT: assert property (i_ce && i_hw_fault |=> o_comm_halt && st_q.fault [*2])
    else $error("Hardware fault not reported");

endmodule // host_board_doorbell_watchdog

// [dv/host_bus_model.sv]
// Host software model: shared-memory accesses toward the board
`timescale 1ns/10ps
module host_bus_model (
  // Clock
  input  wire logic        i_clk,
  // Shared-memory port
  output logic      [15:0] o_addr,
  output logic             o_wr,
  output logic             o_rd,
  output logic      [7:0]  o_wdata,
  input  wire logic [7:0]  i_rdata
);
  // Idle bus at time zero
  initial begin
    o_addr  = 16'h0000;
    o_wr    = 1'b0;
    o_rd    = 1'b0;
    o_wdata = 8'h00;
  end
  // One write strobe; released lines show inverted values
  task automatic write_reg(input logic [15:0] addr, input logic [7:0] data);
    @(posedge i_clk);
    o_addr  <= addr;
    o_wdata <= data;
    o_wr    <= 1'b1;
    @(posedge i_clk);
    o_wr    <= 1'b0;
    o_addr  <= ~addr;
    o_wdata <= ~data;
  endtask
  // One read strobe; data taken once the registered answer has landed
  task automatic read_reg(input logic [15:0] addr, output logic [7:0] data);
    @(posedge i_clk);
    o_addr <= addr;
    o_rd   <= 1'b1;
    @(posedge i_clk);
    o_rd   <= 1'b0;
    o_addr <= ~addr;
    @(posedge i_clk);
    #1 data = i_rdata;
  endtask
  // Raise host causes by writing ones to the trigger register
  task automatic ring(input logic [7:0] causes);
    write_reg(doorbell_pkg::OFS_TRIGGER, causes);
  endtask
  // Poll the confirm register until the causes read zero, bounded
  task automatic wait_confirm(input logic [7:0] causes, output bit ok);
    logic [7:0] v;
    ok = 1'b0;
    for (int n = 0; n < 50 && !ok; n++) begin
      read_reg(doorbell_pkg::OFS_CONFIRM, v);
      ok = ((v & causes) === 8'h00);
    end
  endtask
  // Periodic refresh of the host watchdog
  task automatic refresh(input int times, input int gap);
    repeat (times) begin
      ring(8'h01 << doorbell_pkg::HC_WDT_REF);
      repeat (gap) @(posedge i_clk);
    end
  endtask
endmodule // host_bus_model

// [dv/host_board_doorbell_watchdog_bench.sv]
// Self-checking bench for the host doorbell and watchdog block
`timescale 1ns/10ps
module host_board_doorbell_watchdog_bench;
  localparam int TICKS = 4;  // Short watchdog tick for simulation
  logic        sys_clk, rst_n, hw_fault, bus_irq_n, comm_halt, cycle_run, io_run, st_rd, st_clr, wr, rd;
  logic [7:0]  host_done, board_set, rdata, wdata, pending, v;
  logic [15:0] addr;
  logic        ce;  // Clock enable to the block
  int          err_total, comparisons, cycles, rd_pulses, clr_pulses;
  bit          ok;
  // Clock, 50 ns period
  always #25 sys_clk = ~sys_clk;
  // Host side
  host_bus_model u_host (.i_clk(sys_clk), .o_addr(addr), .o_wr(wr), .o_rd(rd), .o_wdata(wdata), .i_rdata(rdata));
  // Device under test
  host_board_doorbell_watchdog #(.TICK_CYCLES(TICKS)) u_dut (
    .i_sys_clk(sys_clk), .i_rst_n(rst_n), .i_ce(ce), .i_host_addr(addr), .i_host_wr(wr), .i_host_rd(rd),
    .i_host_wdata(wdata), .o_host_rdata(rdata), .o_host_cause_pending(pending), .i_host_done(host_done),
    .i_board_cause_set(board_set), .i_hw_fault(hw_fault), .o_bus_irq_n(bus_irq_n), .o_comm_halt(comm_halt),
    .o_cycle_run(cycle_run), .o_io_run(io_run), .o_status_read_req(st_rd), .o_status_clear_req(st_clr));
  // Verdict and end of run
  task automatic complete_run();
    $display("checks %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // Timeout and pulse counting
  always @(posedge sys_clk) begin
    cycles++;
    if (st_rd === 1'b1) rd_pulses++;
    if (st_clr === 1'b1) clr_pulses++;
    if (cycles == 20000) begin
      err_total++;
      complete_run();
    end
  end
  // Compare one byte
  task automatic check8(input string what, input logic [7:0] exp, input logic [7:0] got);
    comparisons++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  // Let registered updates land
  task automatic settle();
    repeat (2) @(posedge sys_clk);
    #1;
  endtask
  // Synchronous reset for 6 cycles
  task automatic apply_reset();
    @(posedge sys_clk);
    rst_n <= 1'b0;
    repeat (6) @(posedge sys_clk);
    rst_n <= 1'b1;
  endtask
  // One-cycle pulse on a firmware input
  task automatic pulse_done(input logic [7:0] d);
    @(posedge sys_clk);
    host_done <= d;
    @(posedge sys_clk);
    host_done <= 8'h00;
    #1;
  endtask
  task automatic pulse_board(input logic [7:0] d);
    @(posedge sys_clk);
    board_set <= d;
    @(posedge sys_clk);
    board_set <= 8'h00;
  endtask
  // Issue a command, wait for completion, clear its acknowledge
  task automatic do_cmd(input logic [7:0] code);
    u_host.write_reg(doorbell_pkg::OFS_CMD, code);
    u_host.ring(8'h04);
    u_host.wait_confirm(8'h04, ok);
    check8("cmd done", 8'h01, {7'h00, ok});
    u_host.read_reg(doorbell_pkg::OFS_CAUSE, v);
    check8("cmd ack", 8'h04, v & 8'h04);
    u_host.write_reg(doorbell_pkg::OFS_CLEAR, 8'h04);
  endtask
  // Reset values, read-only and unmapped places
  task automatic t_reset();
    check8("irq_n", 8'h01, {7'h00, bus_irq_n});
    check8("pending", 8'h00, pending);
    u_host.write_reg(doorbell_pkg::OFS_CONFIRM, 8'hFF);
    u_host.read_reg(doorbell_pkg::OFS_CONFIRM, v);
    check8("confirm ro", 8'h00, v);
    u_host.read_reg(doorbell_pkg::OFS_MASK, v);
    check8("mask", 8'h00, v);
    u_host.read_reg(16'h00FF, v);
    check8("unmapped", 8'h00, v);
    $display("reset test done");
  endtask
  // Independent host causes completed out of order
  task automatic t_doorbell();
    u_host.ring(8'h1B);
    settle();
    check8("pending", 8'h1B, pending);
    u_host.read_reg(doorbell_pkg::OFS_CONFIRM, v);
    check8("confirm", 8'h1B, v);
    // A completion while the enable is low must be ignored
    @(posedge sys_clk);
    ce <= 1'b0;
    pulse_done(8'h08);
    check8("frozen pending", 8'h1B, pending);
    @(posedge sys_clk);
    ce <= 1'b1;
    pulse_done(8'h08);
    check8("pending", 8'h13, pending);
    pulse_done(8'h01);
    check8("pending", 8'h12, pending);
    pulse_done(8'h12);
    check8("pending", 8'h00, pending);
    $display("doorbell test done");
  endtask
  // Every command code with its cycle state, refusals included
  task automatic t_commands();
    logic [7:0] codes[10] = '{8'h02, 8'h03, 8'h04, 8'h05, 8'h03, 8'h01, 8'h06, 8'h07, 8'h05, 8'h0F};
    logic [1:0] state[10] = '{2'b10, 2'b11, 2'b10, 2'b00, 2'b00, 2'b11, 2'b11, 2'b11, 2'b00, 2'b00};
    for (int i = 0; i < 10; i++) begin
      do_cmd(codes[i]);
      check8("run io", {6'h00, state[i]}, {6'h00, cycle_run, io_run});
    end
    check8("masked irq_n", 8'h01, {7'h00, bus_irq_n});
    check8("read pulses", 8'h01, 8'(rd_pulses));
    check8("clear pulses", 8'h01, 8'(clr_pulses));
    $display("command test done");
  endtask
  // Board causes, mask gating and clearing
  task automatic t_irq();
    pulse_board(8'h10);
    settle();
    check8("masked irq_n", 8'h01, {7'h00, bus_irq_n});
    u_host.read_reg(doorbell_pkg::OFS_CAUSE, v);
    check8("cause", 8'h10, v);
    u_host.write_reg(doorbell_pkg::OFS_MASK, 8'h7F);
    settle();
    check8("irq_n", 8'h00, {7'h00, bus_irq_n});
    u_host.write_reg(doorbell_pkg::OFS_CLEAR, 8'h10);
    for (int b = 0; b < 7; b++) begin
      pulse_board(8'h01 << b);
      settle();
      check8("irq_n", 8'h00, {7'h00, bus_irq_n});
      u_host.read_reg(doorbell_pkg::OFS_CAUSE, v);
      check8("cause", 8'h01 << b, v);
      u_host.write_reg(doorbell_pkg::OFS_CLEAR, 8'h01 << b);
      settle();
      check8("cleared irq_n", 8'h01, {7'h00, bus_irq_n});
    end
    pulse_board(8'h03);
    u_host.write_reg(doorbell_pkg::OFS_CLEAR, 8'h01);
    settle();
    check8("one left irq_n", 8'h00, {7'h00, bus_irq_n});
    // A new board cause in the cycle of its clear must stay pending
    fork
      u_host.write_reg(doorbell_pkg::OFS_CLEAR, 8'h02);
      pulse_board(8'h02);
    join
    settle();
    check8("set wins irq_n", 8'h00, {7'h00, bus_irq_n});
    $display("interrupt test done");
  endtask
  // Watchdog kept alive, then starved
  task automatic t_watchdog();
    do_cmd(8'h01);
    u_host.write_reg(doorbell_pkg::OFS_WDT_CTRL, 8'h07);
    u_host.refresh(6, 3);
    check8("alive halt", 8'h00, {7'h00, comm_halt});
    repeat (20) @(posedge sys_clk);
    #1;
    check8("halt run", 8'h02, {6'h00, comm_halt, cycle_run});
    u_host.read_reg(doorbell_pkg::OFS_STATUS, v);
    check8("status", 8'h02, v);
    u_host.read_reg(doorbell_pkg::OFS_CAUSE, v);
    check8("timeout cause", 8'h40, v & 8'h40);
    do_cmd(8'h01);
    check8("halted run", 8'h00, {7'h00, cycle_run});
    $display("watchdog test done");
  endtask
  // Hardware fault halt reported
  task automatic t_fault();
    @(posedge sys_clk);
    hw_fault <= 1'b1;
    @(posedge sys_clk);
    hw_fault <= 1'b0;
    settle();
    check8("fault halt", 8'h01, {7'h00, comm_halt});
    u_host.read_reg(doorbell_pkg::OFS_STATUS, v);
    check8("status", 8'h01, v);
    $display("fault test done");
  endtask
  // Main sequence
  initial begin
    sys_clk   = 1'b0;
    rst_n     = 1'b0;
    ce        = 1'b1;
    hw_fault  = 1'b0;
    host_done = 8'h00;
    board_set = 8'h00;
    apply_reset();
    t_reset();
    t_doorbell();
    t_commands();
    t_irq();
    apply_reset();
    t_watchdog();
    apply_reset();
    t_fault();
    complete_run();
  end
endmodule // host_board_doorbell_watchdog_bench
